// [common/bsc_consts.vh]
// Purpose: Constants for the bus startup and status control block.
// Assumes: 25 MHz hclk, AHB-Lite register access with word offsets below.
// Notes: Included by every design file of the block.
// How it works
// - Wait a send delay of 2 to 255 s after bus voltage returns.
// - During the delay non-read telegrams are taken but ignored; outputs hold.
// - Nothing is transmitted while the delay runs.
// - At delay end transmit is enabled and outputs are refreshed.
// - Reads arriving during the delay are queued and answered afterwards; the queue holds eight and drops further reads.
// - A two second initialisation lies inside the delay, not added.
// - Rate choice: unlimited, one per second, or one per tenth second.
// - Heartbeat object 0 is off, cyclic value 0, or cyclic value 1.
// - Heartbeat period is 1 to 65535 s, default 60 s.
// - The first heartbeat goes only after the startup delay.
// - A qualifying poll write sends all status messages; the code sends one TX_STAT telegram on the poll object.
// - The poll value is 0 only, 1 only, or either.
// - Each binary input has one of five operating modes.
// - Each blind output pair may act as a single switching output.
// - Output features per output kind; flashing only on 6 A switch outputs.
`ifndef BSC_CONSTS_VH
`define BSC_CONSTS_VH
`define CLK_HZ 25000000
`define TENTH_MS 100
`define TENTH_CYC ((`CLK_HZ / 1000) * `TENTH_MS)
`define TENTHS_PER_S 4'h9
`define INIT_S 8'h02
`define DLY_RST 8'h02
`define CYC_RST 16'h003c
`define POLL_OBJ_RST 8'h01
`define A_CTRL 6'h00
`define A_CYCLE 6'h01
`define A_POLLOBJ 6'h02
`define A_INLO 6'h03
`define A_INHI 6'h04
`define A_OUTCFG 6'h05
`define A_STATUS 6'h06
`define F_DLY 0
`define F_RATE 8
`define F_HB 10
`define F_PEN 12
`define F_PM 13
`define F_FEAT 4
`define RATE_NONE 2'h0
`define RATE_1S 2'h1
`define RATE_TENTH 2'h2
`define HB_OFF 2'h0
`define HB_V0 2'h1
`define HB_V1 2'h2
`define PM_0 2'h0
`define PM_1 2'h1
`define PM_ANY 2'h2
`define IN_DISABLED 3'h0
`define IN_LAST 3'h4
`define TX_HB 2'h0
`define TX_RESP 2'h1
`define TX_STAT 2'h2
`define HB_OBJ 8'h00
`define FT_FLASH 5
`define ST_DOWN 2'h0
`define ST_WAIT 2'h1
`define ST_RUN 2'h2
`endif

// [design/bus_startup_status_control.v]
// Purpose: Startup delay, rate limit, heartbeat and status poll supervision.
// Assumes: Telegram ports are synchronous to hclk; one AHB-Lite slave.
// Notes: A read right after a write to the same register sees the old value.
`timescale 1ns/1ps
`default_nettype none
`include "bsc_consts.vh"
module bus_startup_status_control #(
	parameter TENTH_CYCLES = `TENTH_CYC,
	parameter AW = 3
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	input wire power_ok,
	input wire rx_valid,
	input wire rx_read,
	input wire [7:0] rx_obj,
	input wire rx_val,
	output reg tx_valid,
	input wire tx_ready,
	output reg [1:0] tx_kind,
	output reg [7:0] tx_obj,
	output reg tx_val,
	output reg run,
	output reg out_refresh,
	output reg [35:0] in_mode,
	output reg [3:0] pair_as_switch,
	output reg [47:0] func_en
);
	localparam DEPTH = 1 << AW;
	reg [1:0] state_reg;
	reg [7:0] secs_reg;
	reg restart_reg;
	reg [31:0] ctrl_reg;
	reg [15:0] cycle_reg;
	reg [7:0] poll_obj_reg;
	reg [5:0] feat_reg;
	reg wr_pend_reg;
	reg [5:0] waddr_reg;
	reg [7:0] q_mem [0:DEPTH-1];
	reg [AW-1:0] wp_reg;
	reg [AW-1:0] rp_reg;
	reg [AW:0] qcnt_reg;
	reg [15:0] hb_cnt_reg;
	reg hb_pend_reg;
	reg st_pend_reg;
	wire tenth_tick;
	wire sec_tick;
	wire slot_ok;
	wire [47:0] func_en_next;
	wire [7:0] dly = ctrl_reg[`F_DLY +: 8];
	wire [1:0] rate = ctrl_reg[`F_RATE +: 2];
	wire [1:0] hb_mode = ctrl_reg[`F_HB +: 2];
	wire poll_en = ctrl_reg[`F_PEN];
	wire [1:0] pm = ctrl_reg[`F_PM +: 2];
	wire [7:0] eff_dly = (dly < `INIT_S) ? `INIT_S : dly;
	wire going_run = (state_reg == `ST_WAIT) && sec_tick && (secs_reg == 8'h01) && power_ok;
	wire addr_ph = hsel && hready && htrans[1];
	wire q_full = (qcnt_reg == DEPTH[AW:0]);
	wire q_push = rx_valid && rx_read && (state_reg != `ST_DOWN) && !q_full;
	wire pm_hit = ((pm == `PM_0) && !rx_val) || ((pm == `PM_1) && rx_val) || (pm == `PM_ANY);
	wire poll_hit = rx_valid && !rx_read && (rx_obj == poll_obj_reg) && poll_en && pm_hit && run;
	wire can_send = run && !tx_valid && slot_ok;
	wire send_resp = can_send && (qcnt_reg != {(AW+1){1'b0}});
	wire send_hb = can_send && !send_resp && hb_pend_reg;
	wire send_st = can_send && !send_resp && !hb_pend_reg && st_pend_reg;
	wire launch = send_resp || send_hb || send_st;
	wire hb_due = run && sec_tick && (hb_cnt_reg <= 16'h0001);

	function [17:0] clean_modes;
		input [17:0] m;
		integer k;
		begin
			clean_modes = m;
			for (k = 0; k < 6; k = k + 1)
				if (m[3*k +: 3] > `IN_LAST)
					clean_modes[3*k +: 3] = `IN_DISABLED;
		end
	endfunction

	tick_gen #(
		.TENTH_CYCLES(TENTH_CYCLES)
	) u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.restart(restart_reg),
		.tenth_tick(tenth_tick),
		.sec_tick(sec_tick)
	);

	rate_gate u_rate (
		.hclk(hclk),
		.hresetn(hresetn),
		.tenth_tick(tenth_tick),
		.sec_tick(sec_tick),
		.rate(rate),
		.take(launch),
		.slot_ok(slot_ok)
	);

	// Startup sequencing after bus voltage returns.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= `ST_DOWN;
			secs_reg <= 8'h00;
			restart_reg <= 1'b0;
			run <= 1'b0;
			out_refresh <= 1'b0;
		end
		else
		begin
			restart_reg <= 1'b0;
			out_refresh <= 1'b0;
			case (state_reg)
				`ST_DOWN:
				begin
					run <= 1'b0;
					if (power_ok)
					begin
						state_reg <= `ST_WAIT;
						secs_reg <= eff_dly;
						restart_reg <= 1'b1;
					end
				end
				`ST_WAIT:
				begin
					if (!power_ok)
						state_reg <= `ST_DOWN;
					else if (sec_tick)
					begin
						secs_reg <= secs_reg - 8'h01;
						if (secs_reg == 8'h01)
						begin
							state_reg <= `ST_RUN;
							run <= 1'b1;
							out_refresh <= 1'b1;
						end
					end
				end
				`ST_RUN:
				begin
					if (!power_ok)
					begin
						state_reg <= `ST_DOWN;
						run <= 1'b0;
					end
				end
				default:
				begin
					state_reg <= `ST_DOWN;
					run <= 1'b0;
				end
			endcase
		end
	end

	// Read request queue, answered once running.
	always @(posedge hclk)
	begin
		if (q_push)
			q_mem[wp_reg] <= rx_obj;
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wp_reg <= {AW{1'b0}};
			rp_reg <= {AW{1'b0}};
			qcnt_reg <= {(AW+1){1'b0}};
		end
		else if (state_reg == `ST_DOWN)
		begin
			wp_reg <= {AW{1'b0}};
			rp_reg <= {AW{1'b0}};
			qcnt_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (q_push)
				wp_reg <= wp_reg + {{(AW-1){1'b0}}, 1'b1};
			if (send_resp)
				rp_reg <= rp_reg + {{(AW-1){1'b0}}, 1'b1};
			if (q_push && !send_resp)
				qcnt_reg <= qcnt_reg + {{AW{1'b0}}, 1'b1};
			else if (send_resp && !q_push)
				qcnt_reg <= qcnt_reg - {{AW{1'b0}}, 1'b1};
		end
	end

	// Heartbeat timing and pending sends.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hb_cnt_reg <= `CYC_RST;
			hb_pend_reg <= 1'b0;
			st_pend_reg <= 1'b0;
		end
		else
		begin
			if (!run && !going_run)
				st_pend_reg <= 1'b0;
			else if (poll_hit)
				st_pend_reg <= 1'b1;
			else if (send_st)
				st_pend_reg <= 1'b0;
			if (hb_mode == `HB_OFF || (!run && !going_run))
			begin
				hb_pend_reg <= 1'b0;
				hb_cnt_reg <= cycle_reg;
			end
			else if (going_run || hb_due)
			begin
				hb_pend_reg <= 1'b1;
				hb_cnt_reg <= cycle_reg;
			end
			else
			begin
				if (run && sec_tick)
					hb_cnt_reg <= hb_cnt_reg - 16'h0001;
				if (send_hb)
					hb_pend_reg <= 1'b0;
			end
		end
	end

	// Transmit port, held until the link takes it.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_valid <= 1'b0;
			tx_kind <= `TX_HB;
			tx_obj <= 8'h00;
			tx_val <= 1'b0;
		end
		else if (!run || !power_ok)
			tx_valid <= 1'b0;
		else if (launch)
		begin
			tx_valid <= 1'b1;
			if (send_resp)
			begin
				tx_kind <= `TX_RESP;
				tx_obj <= q_mem[rp_reg];
				tx_val <= 1'b0;
			end
			else if (send_hb)
			begin
				tx_kind <= `TX_HB;
				tx_obj <= `HB_OBJ;
				tx_val <= (hb_mode == `HB_V1);
			end
			else
			begin
				tx_kind <= `TX_STAT;
				tx_obj <= poll_obj_reg;
				tx_val <= 1'b0;
			end
		end
		else if (tx_ready)
			tx_valid <= 1'b0;
	end

	// AHB-Lite slave, zero wait states, always OKAY.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			wr_pend_reg <= 1'b0;
			waddr_reg <= 6'h00;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_reg <= addr_ph && hwrite;
			if (addr_ph)
				waddr_reg <= haddr[7:2];
			if (addr_ph && !hwrite)
			begin
				case (haddr[7:2])
					`A_CTRL: hrdata <= ctrl_reg;
					`A_CYCLE: hrdata <= {16'h0000, cycle_reg};
					`A_POLLOBJ: hrdata <= {24'h000000, poll_obj_reg};
					`A_INLO: hrdata <= {14'h0000, in_mode[17:0]};
					`A_INHI: hrdata <= {14'h0000, in_mode[35:18]};
					`A_OUTCFG: hrdata <= {22'h000000, feat_reg, pair_as_switch};
					`A_STATUS: hrdata <= {15'h0000, tx_valid, st_pend_reg, hb_pend_reg,
						qcnt_reg, state_reg, secs_reg};
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg <= {24'h000000, `DLY_RST};
			cycle_reg <= `CYC_RST;
			poll_obj_reg <= `POLL_OBJ_RST;
			in_mode <= 36'h000000000;
			pair_as_switch <= 4'h0;
			feat_reg <= 6'h00;
		end
		else if (wr_pend_reg)
		begin
			case (waddr_reg)
				`A_CTRL: ctrl_reg <= {17'h00000, hwdata[14:0]};
				`A_CYCLE: cycle_reg <= hwdata[15:0];
				`A_POLLOBJ: poll_obj_reg <= hwdata[7:0];
				`A_INLO: in_mode[17:0] <= clean_modes(hwdata[17:0]);
				`A_INHI: in_mode[35:18] <= clean_modes(hwdata[17:0]);
				`A_OUTCFG:
				begin
					pair_as_switch <= hwdata[3:0];
					feat_reg <= hwdata[`F_FEAT +: 6];
				end
				default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// Feature enables per output: A..D are 20 A, E/G/I/K the 6 A singles.
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1)
		begin : g_out
			assign func_en_next[6*i +: 6] = (i < 4) ? (feat_reg & ~(6'h01 << `FT_FLASH))
				: (pair_as_switch[i % 4] ? feat_reg : 6'h00);
		end
	endgenerate

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			func_en <= 48'h000000000000;
		else
			func_en <= func_en_next;
	end
endmodule // bus_startup_status_control
`default_nettype wire

// [design/rate_gate.v]
// Purpose: Telegram rate limiter giving send slots.
// Assumes: take is high in the cycle a telegram is launched.
// Notes: A tick in the same cycle as take reopens the slot.
`timescale 1ns/1ps
`default_nettype none
`include "bsc_consts.vh"
module rate_gate (
	input wire hclk,
	input wire hresetn,
	input wire tenth_tick,
	input wire sec_tick,
	input wire [1:0] rate,
	input wire take,
	output wire slot_ok
);
	reg credit_reg;
	assign slot_ok = credit_reg | (rate == `RATE_NONE);
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			credit_reg <= 1'b1;
		else
		begin
			case (rate)
				`RATE_1S:
				begin
					if (sec_tick)
						credit_reg <= 1'b1;
					else if (take)
						credit_reg <= 1'b0;
				end
				`RATE_TENTH:
				begin
					if (tenth_tick)
						credit_reg <= 1'b1;
					else if (take)
						credit_reg <= 1'b0;
				end
				default:
					credit_reg <= 1'b1;
			endcase
		end
	end
endmodule // rate_gate
`default_nettype wire

// [design/tick_gen.v]
// Purpose: Tenth-second and second ticks from hclk.
// Assumes: restart realigns both ticks.
// Notes: Ticks are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "bsc_consts.vh"
module tick_gen #(
	parameter TENTH_CYCLES = `TENTH_CYC,
	parameter CW = 22
) (
	input wire hclk,
	input wire hresetn,
	input wire restart,
	output reg tenth_tick,
	output reg sec_tick
);
	localparam integer LAST_I = TENTH_CYCLES - 1;
	localparam [CW-1:0] LAST = LAST_I[CW-1:0];
	reg [CW-1:0] cnt_reg;
	reg [3:0] sub_reg;
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_reg <= {CW{1'b0}};
			sub_reg <= 4'h0;
			tenth_tick <= 1'b0;
			sec_tick <= 1'b0;
		end
		else if (restart)
		begin
			cnt_reg <= {CW{1'b0}};
			sub_reg <= 4'h0;
			tenth_tick <= 1'b0;
			sec_tick <= 1'b0;
		end
		else
		begin
			tenth_tick <= 1'b0;
			sec_tick <= 1'b0;
			if (cnt_reg == LAST)
			begin
				cnt_reg <= {CW{1'b0}};
				tenth_tick <= 1'b1;
				if (sub_reg == `TENTHS_PER_S)
				begin
					sub_reg <= 4'h0;
					sec_tick <= 1'b1;
				end
				else
					sub_reg <= sub_reg + 4'h1;
			end
			else
				cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
		end
	end
endmodule // tick_gen
`default_nettype wire

// [sim/bus_startup_status_control_sva.sv]
// Purpose: Port checker for the startup and status control block.
// Assumes: Bound to every instance; TENTH_CYCLES as given to the block.
// Notes: Watches bus voltage, telegram, run and output configuration ports only.
`timescale 1ns/1ps
`default_nettype none
`include "bsc_consts.vh"
module bssc_checker #(
	parameter TENTH_CYCLES = `TENTH_CYC
) (
	input wire hclk,
	input wire hresetn,
	input wire power_ok,
	input wire tx_ready,
	input wire tx_valid,
	input wire [1:0] tx_kind,
	input wire [7:0] tx_obj,
	input wire tx_val,
	input wire run,
	input wire out_refresh,
	input wire [35:0] in_mode,
	input wire [3:0] pair_as_switch,
	input wire [47:0] func_en
);
	logic [31:0] up_cnt;
	// Counts cycles since bus voltage came back.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			up_cnt <= 32'h0;
		else
			up_cnt <= power_ok ? up_cnt + 32'h1 : 32'h0;
	end
	function automatic logic modes_ok(input logic [35:0] m);
		for (int i = 0; i < 12; i++)
			if (m[3*i+:3] > `IN_LAST)
				return 1'b0;
		return 1'b1;
	endfunction
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_quiet; !run |-> !tx_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("telegram offered while stopped");
	property p_drop; !power_ok |=> !run && !tx_valid; endproperty
	a_drop: assert property (p_drop) else $error("still active without bus voltage");
	property p_hold; tx_valid && !tx_ready |=> !power_ok || (tx_valid && $stable(tx_kind)
		&& $stable(tx_obj) && $stable(tx_val)); endproperty
	a_hold: assert property (p_hold) else $error("telegram changed before acceptance");
	property p_refresh; $rose(run) |-> out_refresh ##1 !out_refresh; endproperty
	a_refresh: assert property (p_refresh) else $error("no refresh pulse at delay end");
	property p_refresh_run; $rose(out_refresh) |-> $rose(run); endproperty
	a_refresh_run: assert property (p_refresh_run) else $error("refresh outside delay end");
	property p_first; $rose(run) |-> !tx_valid; endproperty
	a_first: assert property (p_first) else $error("telegram before delay end");
	property p_delay; $rose(run) |-> up_cnt >= 64'd20 * TENTH_CYCLES && up_cnt <= 64'd2550 * TENTH_CYCLES + 64'd4;
	endproperty
	a_delay: assert property (p_delay) else $error("startup delay out of range");
	property p_hb_obj; tx_valid && tx_kind == `TX_HB |-> tx_obj == `HB_OBJ; endproperty
	a_hb_obj: assert property (p_hb_obj) else $error("heartbeat on wrong object");
	property p_kind; tx_valid |-> tx_kind != 2'h3 && (tx_kind == `TX_HB || !tx_val); endproperty
	a_kind: assert property (p_kind) else $error("bad telegram kind or value");
	property p_modes; modes_ok(in_mode); endproperty
	a_modes: assert property (p_modes) else $error("illegal input mode");
	property p_flash; !(func_en[5] | func_en[11] | func_en[17] | func_en[23]); endproperty
	a_flash: assert property (p_flash) else $error("flash on a heavy output");
	property p_pair; (func_en[29:24] == 6'h0 || pair_as_switch[0]) && (func_en[35:30] == 6'h0 || pair_as_switch[1])
		&& (func_en[41:36] == 6'h0 || pair_as_switch[2]) && (func_en[47:42] == 6'h0 || pair_as_switch[3]); endproperty
	a_pair: assert property (p_pair) else $error("switch features on a blind pair");
endmodule // bssc_checker
bind bus_startup_status_control bssc_checker #(.TENTH_CYCLES(TENTH_CYCLES)) i_chk (.hclk(hclk), .hresetn(hresetn),
	.power_ok(power_ok), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_kind(tx_kind), .tx_obj(tx_obj),
	.tx_val(tx_val), .run(run), .out_refresh(out_refresh), .in_mode(in_mode), .pair_as_switch(pair_as_switch),
	.func_en(func_en));
`default_nettype wire

// [sim/bus_startup_status_control_tb_top.sv]
// Purpose: Self-checking bench for the startup and status control block.
// Assumes: One second is ten tenth ticks of TC cycles.
// Notes: Registers are reached through AHB-Lite single word transfers.
`timescale 1ns/1ps
`default_nettype none
`include "bsc_consts.vh"
module bus_startup_status_control_tb_top;
	localparam int TC = 10;
	localparam int SEC = 10 * TC;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic power_ok = 1'b0;
	logic slow = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	wire hreadyout, hresp, tx_valid, tx_ready, rx_valid, rx_read, rx_val, tx_val, run, out_refresh;
	wire [31:0] hrdata;
	wire [1:0] tx_kind;
	wire [7:0] tx_obj, rx_obj;
	wire [35:0] in_mode;
	wire [3:0] pair_as_switch;
	wire [47:0] func_en;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	always #20 hclk = ~hclk;
	bus_startup_status_control #(.TENTH_CYCLES(TC)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .power_ok, .rx_valid, .rx_read, .rx_obj,
		.rx_val, .tx_valid, .tx_ready, .tx_kind, .tx_obj, .tx_val, .run, .out_refresh, .in_mode, .pair_as_switch,
		.func_en);
	link_model i_link (.hclk, .tx_valid, .tx_kind, .tx_obj, .tx_val, .slow, .tx_ready, .rx_valid, .rx_read,
		.rx_obj, .rx_val);
	task report_and_stop;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc > 40000)
		begin
			mismatches++;
			report_and_stop;
		end
	end
	task chk(input logic [47:0] seen, input logic [47:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge hclk);
	endtask
	function automatic logic [31:0] ba(input logic [5:0] i);
		return {24'h0, i, 2'h0};
	endfunction
	task rdy;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		chk(hresp, 1'b0);
	endtask
	task clear;
		i_link.log_q.delete();
		i_link.t_q.delete();
	endtask
	initial
	begin
		int t0;
		int e;
		step(8);
		hresetn <= 1'b1;
		step(1);
		ahb(0, ba(`A_CTRL), 0);
		chk(rd, `DLY_RST);
		ahb(0, ba(`A_CYCLE), 0);
		chk(rd, `CYC_RST);
		ahb(0, ba(`A_POLLOBJ), 0);
		chk(rd, `POLL_OBJ_RST);
		ahb(0, 32'h1c, 0);
		chk(rd, 0);
		ahb(0, ba(`A_STATUS), 0);
		chk(rd[9:8], `ST_DOWN);
		ahb(1, ba(`A_INLO), 32'h2c688);
		ahb(1, ba(`A_INHI), 32'h0a7ec);
		ahb(1, ba(`A_OUTCFG), 32'h3f1);
		step(2);
		chk(in_mode[17:0], 18'h04688);
		chk(in_mode[35:18], 18'h0a604);
		ahb(0, ba(`A_INHI), 0);
		chk(rd[17:0], 18'h0a604);
		chk(pair_as_switch, 4'h1);
		chk(func_en, {18'h0, 6'h3f, {4{6'h1f}}});
		$display("test config done");
		ahb(1, ba(`A_CTRL), 32'h5803);
		ahb(1, ba(`A_CYCLE), 1);
		slow <= 1'b1;
		power_ok <= 1'b1;
		t0 = cyc;
		step(5);
		i_link.send(1, 8'h05, 0);
		i_link.send(0, `POLL_OBJ_RST, 1);
		ahb(0, ba(`A_STATUS), 0);
		chk(rd[16:8], {3'h0, 4'h1, `ST_WAIT});
		while (run !== 1'b1)
			@(negedge hclk);
		chk((cyc - t0) inside {[3*SEC:3*SEC+5]}, 1);
		step(60);
		chk(i_link.log_q.size(), 2);
		chk(i_link.log_q[0], {`TX_RESP, 8'h05, 1'b0});
		chk(i_link.log_q[1], {`TX_HB, `HB_OBJ, 1'b1});
		ahb(0, ba(`A_STATUS), 0);
		chk(rd[9:8], `ST_RUN);
		$display("test startup done");
		slow <= 1'b0;
		ahb(1, ba(`A_CTRL), 32'h0403);
		ahb(1, ba(`A_CYCLE), 2);
		clear;
		while (i_link.log_q.size() < 3)
			@(posedge hclk);
		chk((i_link.t_q[2] - i_link.t_q[1]) inside {[2*SEC-1:2*SEC+1]}, 1);
		chk(i_link.log_q[2], {`TX_HB, `HB_OBJ, 1'b0});
		$display("test heartbeat done");
		for (int r = 0; r < 3; r++)
		begin
			ahb(1, ba(`A_CTRL), 32'h5003 | (r << 8));
			step(5);
			clear;
			repeat (3) i_link.send(1, 8'h07, 0);
			while (i_link.log_q.size() < 3)
				@(posedge hclk);
			e = i_link.t_q[2] - i_link.t_q[1];
			chk(r == 0 ? e < TC : (r == 1 ? e inside {[SEC-1:SEC+1]} : e inside {[TC-1:TC+1]}), 1);
		end
		$display("test rate done");
		for (int p = 0; p < 4; p++)
			for (int v = 0; v < 2; v++)
			begin
				ahb(1, ba(`A_CTRL), 32'h1003 | (p << 13));
				step(20);
				clear;
				i_link.send(0, `POLL_OBJ_RST, v[0]);
				step(30);
				chk(i_link.log_q.size(), p == 2 || p == v);
				if (i_link.log_q.size() > 0)
					chk(i_link.log_q[0], {`TX_STAT, `POLL_OBJ_RST, 1'b0});
			end
		$display("test poll done");
		power_ok <= 1'b0;
		step(3);
		@(negedge hclk);
		chk(run, 0);
		$display("test power drop done");
		report_and_stop;
	end
endmodule // bus_startup_status_control_tb_top
`default_nettype wire

// [sim/link_model.sv]
// Purpose: Field bus side: accepts telegrams and sends received ones.
// Assumes: slow makes acceptance wait four cycles.
// Notes: Logs every accepted telegram with its cycle.
`timescale 1ns/1ps
`default_nettype none
module link_model (
	input wire logic hclk,
	input wire logic tx_valid,
	input wire logic [1:0] tx_kind,
	input wire logic [7:0] tx_obj,
	input wire logic tx_val,
	input wire logic slow,
	output logic tx_ready,
	output logic rx_valid,
	output logic rx_read,
	output logic [7:0] rx_obj,
	output logic rx_val
);
	logic [10:0] log_q[$];
	int t_q[$];
	int cyc = 0;
	logic [1:0] w = 2'h0;
	logic rd_r = 1'b0;
	logic val_r = 1'b0;
	logic [7:0] obj_r = 8'h0;
	initial tx_ready = 1'b0;
	initial rx_valid = 1'b0;
	// Idle receive lines wander so a stale value is never seen.
	assign rx_obj = rx_valid ? obj_r : ~obj_r ^ cyc[7:0];
	assign rx_read = rx_valid ? rd_r : cyc[0];
	assign rx_val = rx_valid ? val_r : ~cyc[0];
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (tx_valid && tx_ready)
		begin
			log_q.push_back({tx_kind, tx_obj, tx_val});
			t_q.push_back(cyc);
		end
		w <= (tx_valid && !tx_ready) ? w + 2'h1 : 2'h0;
		tx_ready <= tx_valid && !tx_ready && (!slow || w == 2'h3);
	end
	task send(input logic rd, input logic [7:0] obj, input logic val);
		@(posedge hclk);
		rx_valid <= 1'b1;
		rd_r <= rd;
		obj_r <= obj;
		val_r <= val;
		@(posedge hclk);
		rx_valid <= 1'b0;
	endtask
endmodule // link_model
`default_nettype wire
